/* shared/pocr_map.vh */
// Register offsets, keys, field positions and timing constants of the protected bank
`ifndef POCR_MAP_VH
`define POCR_MAP_VH
`define POCR_ADDR_UNLOCK 8'h3F
`define POCR_ADDR_KEY 8'h3A
`define POCR_ADDR_FEAT 8'h40
`define POCR_ADDR_IO 8'h41
`define POCR_ADDR_OVTH 8'h42
`define POCR_ADDR_OVDL 8'h43
`define POCR_ADDR_UVTH 8'h44
`define POCR_ADDR_UVDL 8'h45
`define POCR_ADDR_OTTH 8'h46
`define POCR_ADDR_OTDL 8'h47
`define POCR_ADDR_USER_STORAGE_1 8'h48
`define POCR_ADDR_USER_STORAGE_4 8'h4B
`define POCR_PROT_LO 8'h40
`define POCR_PROT_HI 8'h4F
`define POCR_BANK_BASE 8'h40
`define POCR_BANK_LAST 4'hB
`define POCR_UNLOCK_KEY 8'h91
`define POCR_UNLOCK_OFF 8'h00
`define POCR_WRITE_KEY 8'h35
`define POCR_RELOAD_KEY 8'h27
`define POCR_ZERO8 8'h00
`define POCR_CONVERSION_TIME_SEL_HI 7
`define POCR_CONVERSION_TIME_SEL_LO 6
`define POCR_AUXREF_BIT 5
`define POCR_AUXSRC_BIT 4
`define POCR_CN_HI 3
`define POCR_CN_LO 2
`define POCR_CRCOFF_BIT 0
`define POCR_DISABLE_BIT 7
`define POCR_UNIT_BIT 7
`define POCR_DLY_HI 4
`define POCR_OVCODE_HI 5
`define POCR_UVCODE_HI 4
`define POCR_OVCODE_MAX 6'h3C
`define POCR_UVCODE_MAX 5'h1A
`define POCR_OTCODE_MAX 4'hB
`define POCR_OV_BASE_MV 16'd2000
`define POCR_OV_STEP_MV 16'd50
`define POCR_UV_BASE_MV 16'd700
`define POCR_UV_STEP_MV 16'd100
`define POCR_DLY_STEP 16'd100
`define POCR_OT_STEP_MS 16'd10
`define POCR_CLK_HZ 32'd10000000
`define POCR_PROGRAMMING_PIN_PULSE_US 32'd2000
`endif

/* core/pocr_protected_config.v */
// Protected one-time-programmable configuration register bank
`default_nettype none
// ----------------------------------------------------------------
// How it works
// - Writing 0x91 to the unlock register opens the programming window.
// - Any next read or write transaction closes the programming window.
// - A protected write while the window is open closes it afterwards.
// - Feature bits 7:6 select conversion time 3, 6, 12 or 24 us.
// - Feature bit 5 picks bandgap or five volt aux reference.
// - Feature bit 4 routes aux result: external inputs or pack pin.
// - Feature bits 3:2 set cell count; faults above it are ignored.
// - I/O bit 0 clear means packets carry a CRC byte.
// - Host sets read length; device checks CRC at chip select release.
// - Overvoltage threshold: bit 7 disables; 2 V plus 50 mV per code.
// - Overvoltage delay: bit 7 unit; code times 100 units.
// - Overvoltage delay register all zero: flags follow live comparator, no latch.
// - Undervoltage threshold: bit 7 disables; 0.7 V plus 100 mV per code.
// - Undervoltage delay: bit 7 unit; code times 100 units.
// - Undervoltage delay register all zero: flags follow live comparator, no latch.
// - Over-temperature threshold: one nibble per input; zero disables it.
// - Over-temperature delay: code times 10 ms.
// - Over-temperature delay zero: flags follow live comparator, no latch.
// - Four user bytes at 0x48 to 0x4b with no internal use.
// - Unlock write with progVoltageOk high after staging values starts a self-timed program pulse.
// - Key 0x35 before each protected write; cleared after any write other than a key write that loads a new key.
// - Writing 0x27 reloads the bank from memory; the key clears in the same cycle.
// ----------------------------------------------------------------
`include "pocr_map.vh"

module pocr_protected_config #(
  parameter PROGRAMMING_PIN_PULSE_CYCLES = (`POCR_PROGRAMMING_PIN_PULSE_US * (`POCR_CLK_HZ / 32'd1000000))
) (
  input wire clk,
  input wire reset,
  input wire txnStart,
  input wire wrEn,
  input wire rdEn,
  input wire [7:0] addr,
  input wire [7:0] wrData,
  input wire progVoltageOk,
  input wire [95:0] otpData,
  output reg [7:0] rdData_q,
  output reg rdValid_q,
  output reg windowOpen_q,
  output reg progPulse_q,
  output reg [95:0] otpProgData_q,
  output reg [1:0] conversionTimeSel_q,
  output reg auxInputRefSel_q,
  output reg auxInputSrcSel_q,
  output reg [5:0] cellEnable_q,
  output reg crcOff_q,
  output reg ovEnable_q,
  output reg [15:0] ovThresholdMv_q,
  output reg ovUnitMs_q,
  output reg [15:0] ovDelay_q,
  output reg ovLatch_q,
  output reg uvEnable_q,
  output reg [15:0] uvThresholdMv_q,
  output reg uvUnitMs_q,
  output reg [15:0] uvDelay_q,
  output reg uvLatch_q,
  output reg [3:0] otThresholdFirst_q,
  output reg [3:0] otThresholdSecond_q,
  output reg [15:0] otDelayMs_q,
  output reg otLatch_q
);

// ----------------------------------------------------------------
// Bank storage and helpers
// ----------------------------------------------------------------
reg [7:0] bank_q [0:11];
reg [7:0] writeKey_q;
reg loadPending_q;
reg [31:0] pulseCnt_q;
integer i;

wire inBank = (addr >= `POCR_BANK_BASE) && (addr[3:0] <= `POCR_BANK_LAST)
  && (addr[7:4] == `POCR_BANK_BASE >> 4);
wire inProt = (addr >= `POCR_PROT_LO) && (addr <= `POCR_PROT_HI);
wire [3:0] idx = addr[3:0];
wire protWrite = wrEn && inProt && (writeKey_q == `POCR_WRITE_KEY);

// Delay in units: code times step; zero code means zero delay
function [15:0] delayOf;
  input [4:0] code;
  begin
    delayOf = {11'h000, code} * `POCR_DLY_STEP;
  end
endfunction

// Cell count code 00=6 .. 11=3 turned into a per-cell enable mask
function [5:0] cellMask;
  input [1:0] cn;
  begin
    case (cn)
      2'b00: cellMask = 6'h3F;
      2'b01: cellMask = 6'h1F;
      2'b10: cellMask = 6'h0F;
      default: cellMask = 6'h07;
    endcase
  end
endfunction

// Codes past the printed maximum saturate so the comparators never see nonsense
function [15:0] ovMv;
  input [5:0] code;
  reg [5:0] c;
  begin
    c = (code > `POCR_OVCODE_MAX) ? `POCR_OVCODE_MAX : code;
    ovMv = `POCR_OV_BASE_MV + {10'h000, c} * `POCR_OV_STEP_MV;
  end
endfunction

function [15:0] uvMv;
  input [4:0] code;
  reg [4:0] c;
  begin
    c = (code > `POCR_UVCODE_MAX) ? `POCR_UVCODE_MAX : code;
    uvMv = `POCR_UV_BASE_MV + {11'h000, c} * `POCR_UV_STEP_MV;
  end
endfunction

function [3:0] otCode;
  input [3:0] code;
  begin
    otCode = (code > `POCR_OTCODE_MAX) ? `POCR_OTCODE_MAX : code;
  end
endfunction

// ----------------------------------------------------------------
// Transaction decode
// ----------------------------------------------------------------
integer j;
wire keyWrite = wrEn && (addr == `POCR_ADDR_KEY);
wire unlockWrite = wrEn && (addr == `POCR_ADDR_UNLOCK);
wire unlockKey = (wrData == `POCR_UNLOCK_KEY);
wire reloadReq = keyWrite && (wrData == `POCR_RELOAD_KEY);
wire bankLoad = loadPending_q || reloadReq;
// A running pulse is never restarted: a second unlock would stretch the programming time
wire pulseStart = unlockWrite && unlockKey && progVoltageOk && !progPulse_q;

// ----------------------------------------------------------------
// Bank storage and reload
// ----------------------------------------------------------------
always @(posedge clk or posedge reset) begin
  if (reset) begin
    for (i = 0; i < 12; i = i + 1) begin
      bank_q[i] <= `POCR_ZERO8;
    end
    loadPending_q <= 1'b1;
  end else begin
    loadPending_q <= 1'b0;
    if (bankLoad) begin
      // Defaults come from the programmed memory, not from constants
      for (i = 0; i < 12; i = i + 1) begin
        bank_q[i] <= otpData[i*8 +: 8];
      end
    end else if (protWrite && inBank) begin
      bank_q[idx] <= wrData;
    end
  end
end

// ----------------------------------------------------------------
// Protection key
// ----------------------------------------------------------------
always @(posedge clk or posedge reset) begin
  if (reset) begin
    writeKey_q <= `POCR_ZERO8;
  end else if (wrEn) begin
    // Any write uses up the key, so one key guards exactly one protected write
    if (keyWrite && !reloadReq) begin
      writeKey_q <= wrData;
    end else begin
      writeKey_q <= `POCR_ZERO8;
    end
  end
end

// ----------------------------------------------------------------
// Programming window
// ----------------------------------------------------------------
always @(posedge clk or posedge reset) begin
  if (reset) begin
    windowOpen_q <= 1'b0;
  end else begin
    if (txnStart && windowOpen_q) begin
      windowOpen_q <= 1'b0;
    end
    if (unlockWrite) begin
      // Zero or a reserved value keeps the window shut
      windowOpen_q <= unlockKey;
    end
    if (protWrite && windowOpen_q) begin
      windowOpen_q <= 1'b0;
    end
  end
end

// ----------------------------------------------------------------
// Read path
// ----------------------------------------------------------------
always @(posedge clk or posedge reset) begin
  if (reset) begin
    rdData_q <= `POCR_ZERO8;
    rdValid_q <= 1'b0;
  end else begin
    rdValid_q <= rdEn;
    if (rdEn) begin
      if (inBank) begin
        rdData_q <= bank_q[idx];
      end else begin
        // Key register always reads zero; unmapped reads return zero
        rdData_q <= `POCR_ZERO8;
      end
    end
  end
end

// ----------------------------------------------------------------
// Self-timed programming pulse
// ----------------------------------------------------------------
always @(posedge clk or posedge reset) begin
  if (reset) begin
    progPulse_q <= 1'b0;
    pulseCnt_q <= 32'h00000000;
    otpProgData_q <= 96'h0;
  end else if (pulseStart) begin
    progPulse_q <= 1'b1;
    pulseCnt_q <= PROGRAMMING_PIN_PULSE_CYCLES;
    for (j = 0; j < 12; j = j + 1) begin
      otpProgData_q[j*8 +: 8] <= bank_q[j];
    end
  end else if (progPulse_q) begin
    if (pulseCnt_q <= 32'h00000001) begin
      progPulse_q <= 1'b0;
      pulseCnt_q <= 32'h00000000;
    end else begin
      pulseCnt_q <= pulseCnt_q - 32'h00000001;
    end
  end
end

// ----------------------------------------------------------------
// Decoded feature and I/O settings
// ----------------------------------------------------------------
always @(posedge clk or posedge reset) begin
  if (reset) begin
    conversionTimeSel_q <= 2'b00;
    auxInputRefSel_q <= 1'b0;
    auxInputSrcSel_q <= 1'b0;
    cellEnable_q <= 6'h00;
  end else begin
    conversionTimeSel_q <= bank_q[0][`POCR_CONVERSION_TIME_SEL_HI:`POCR_CONVERSION_TIME_SEL_LO];
    auxInputRefSel_q <= bank_q[0][`POCR_AUXREF_BIT];
    auxInputSrcSel_q <= bank_q[0][`POCR_AUXSRC_BIT];
    cellEnable_q <= cellMask(bank_q[0][`POCR_CN_HI:`POCR_CN_LO]);
  end
end

always @(posedge clk or posedge reset) begin
  if (reset) begin
    crcOff_q <= 1'b0;
  end else begin
    // The serial framing reads this to add or check the trailing CRC byte
    crcOff_q <= bank_q[1][`POCR_CRCOFF_BIT];
  end
end

// ----------------------------------------------------------------
// Decoded overvoltage settings
// ----------------------------------------------------------------
always @(posedge clk or posedge reset) begin
  if (reset) begin
    ovEnable_q <= 1'b0;
    ovThresholdMv_q <= 16'h0000;
  end else begin
    ovEnable_q <= ~bank_q[2][`POCR_DISABLE_BIT];
    ovThresholdMv_q <= ovMv(bank_q[2][`POCR_OVCODE_HI:0]);
  end
end

always @(posedge clk or posedge reset) begin
  if (reset) begin
    ovUnitMs_q <= 1'b0;
    ovDelay_q <= 16'h0000;
    ovLatch_q <= 1'b0;
  end else begin
    // Only an all-zero register drops the latch; the unit bit alone keeps it
    ovUnitMs_q <= bank_q[3][`POCR_UNIT_BIT];
    ovDelay_q <= delayOf(bank_q[3][`POCR_DLY_HI:0]);
    ovLatch_q <= (bank_q[3] != `POCR_ZERO8);
  end
end

// ----------------------------------------------------------------
// Decoded undervoltage settings
// ----------------------------------------------------------------
always @(posedge clk or posedge reset) begin
  if (reset) begin
    uvEnable_q <= 1'b0;
    uvThresholdMv_q <= 16'h0000;
  end else begin
    uvEnable_q <= ~bank_q[4][`POCR_DISABLE_BIT];
    uvThresholdMv_q <= uvMv(bank_q[4][`POCR_UVCODE_HI:0]);
  end
end

always @(posedge clk or posedge reset) begin
  if (reset) begin
    uvUnitMs_q <= 1'b0;
    uvDelay_q <= 16'h0000;
    uvLatch_q <= 1'b0;
  end else begin
    uvUnitMs_q <= bank_q[5][`POCR_UNIT_BIT];
    uvDelay_q <= delayOf(bank_q[5][`POCR_DLY_HI:0]);
    uvLatch_q <= (bank_q[5] != `POCR_ZERO8);
  end
end

// ----------------------------------------------------------------
// Decoded over-temperature settings
// ----------------------------------------------------------------
always @(posedge clk or posedge reset) begin
  if (reset) begin
    otThresholdFirst_q <= 4'h0;
    otThresholdSecond_q <= 4'h0;
  end else begin
    otThresholdFirst_q <= otCode(bank_q[6][3:0]);
    otThresholdSecond_q <= otCode(bank_q[6][7:4]);
  end
end

always @(posedge clk or posedge reset) begin
  if (reset) begin
    otDelayMs_q <= 16'h0000;
    otLatch_q <= 1'b0;
  end else begin
    otDelayMs_q <= {8'h00, bank_q[7]} * `POCR_OT_STEP_MS;
    otLatch_q <= (bank_q[7] != `POCR_ZERO8);
  end
end

endmodule // pocr_protected_config
`default_nettype wire

/* test/pocr_protected_config_assertions.sv */
// Checker for the protected configuration bank
`default_nettype none
module pocr_checker (
  input wire clk,
  input wire reset,
  input wire txnStart,
  input wire wrEn,
  input wire rdEn,
  input wire [7:0] addr,
  input wire [7:0] wrData,
  input wire progVoltageOk,
  input wire rdValid_q,
  input wire windowOpen_q,
  input wire progPulse_q,
  input wire [15:0] ovThresholdMv_q,
  input wire [15:0] ovDelay_q,
  input wire ovLatch_q,
  input wire [15:0] uvDelay_q,
  input wire uvLatch_q,
  input wire [15:0] otDelayMs_q,
  input wire otLatch_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  read_answer_a: assert property (rdEn |=> rdValid_q)
    else $error("read got no answer");
  window_open_a: assert property (wrEn && !txnStart && addr == 8'h3F && wrData == 8'h91
    && progVoltageOk |=> windowOpen_q) else $error("unlock did not open window");
  window_close_a: assert property (windowOpen_q && txnStart |=> !windowOpen_q)
    else $error("window stayed open");
  pulse_cause_a: assert property ($rose(progPulse_q) |-> windowOpen_q && $past(wrData) == 8'h91)
    else $error("pulse without unlock");
  pulse_hold_a: assert property ($rose(progPulse_q) |-> progPulse_q [*8])
    else $error("pulse too short");
  ov_latch_a: assert property ((ovDelay_q != 16'h0000) |-> ovLatch_q)
    else $error("ov latch mode wrong");
  uv_latch_a: assert property ((uvDelay_q != 16'h0000) |-> uvLatch_q)
    else $error("uv latch mode wrong");
  ot_latch_a: assert property (otLatch_q == (otDelayMs_q != 16'h0000))
    else $error("ot latch mode wrong");
  ov_range_a: assert property (ovThresholdMv_q <= 16'h1388 && ovThresholdMv_q % 50 == 0)
    else $error("ov threshold off scale");
  cover property (windowOpen_q ##1 !windowOpen_q);
  cover property ($fell(progPulse_q));
  cover property (rdEn ##1 rdValid_q);
endmodule // pocr_checker
bind pocr_protected_config pocr_checker u_chk (.clk(clk), .reset(reset), .txnStart(txnStart),
  .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData), .progVoltageOk(progVoltageOk),
  .rdValid_q(rdValid_q), .windowOpen_q(windowOpen_q), .progPulse_q(progPulse_q),
  .ovThresholdMv_q(ovThresholdMv_q), .ovDelay_q(ovDelay_q), .ovLatch_q(ovLatch_q),
  .uvDelay_q(uvDelay_q), .uvLatch_q(uvLatch_q), .otDelayMs_q(otDelayMs_q), .otLatch_q(otLatch_q));
`default_nettype wire

/* test/pocr_host_model.sv */
// Host side model issuing register transactions
`default_nettype none
module pocr_host_model (
  input wire logic clk,
  output logic txnStart,
  output logic wrEn,
  output logic rdEn,
  output logic [7:0] addr,
  output logic [7:0] wrData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {txnStart, wrEn, rdEn, addr, wrData} = '0;
  end
  // Transaction start leads the byte by one cycle so an unlock is not closed by itself
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    txnStart = 1'b1;
    @(posedge clk) #1;
    txnStart = 1'b0;
    {wrEn, rdEn, addr, wrData} = {w, !w, a, d};
    @(posedge clk) #1;
    // Released lines show the inverse so a stale copy cannot pass
    {wrEn, rdEn, addr, wrData} = {1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic prot(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, 8'h3A, 8'h35);
    xfer(1'b1, a, d);
  endtask
endmodule // pocr_host_model
`default_nettype wire

/* test/pocr_protected_config_tb.sv */
// Self-checking bench for the protected configuration bank
`default_nettype none
module pocr_protected_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [95:0] IMG = 96'h44332211_0A21001A_003C0164;
  logic clk, reset, progVoltageOk, txnStart, wrEn, rdEn, rdValid_q, windowOpen_q, progPulse_q;
  logic auxInputRefSel_q, crcOff_q, ovEnable_q, ovUnitMs_q, ovLatch_q, uvLatch_q, otLatch_q;
  logic auxInputSrcSel_q, uvEnable_q, uvUnitMs_q;
  logic [15:0] uvThresholdMv_q;
  logic [3:0] otThresholdFirst_q, otThresholdSecond_q;
  logic [7:0] addr, wrData, rdData_q;
  logic [1:0] conversionTimeSel_q;
  logic [5:0] cellEnable_q;
  logic [15:0] ovThresholdMv_q, ovDelay_q, uvDelay_q, otDelayMs_q;
  logic [95:0] otpProgData_q;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  pocr_host_model host (.clk(clk), .txnStart(txnStart), .wrEn(wrEn), .rdEn(rdEn),
    .addr(addr), .wrData(wrData));
  pocr_protected_config #(.PROGRAMMING_PIN_PULSE_CYCLES(10)) DUT (.clk(clk), .reset(reset),
    .txnStart(txnStart), .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData),
    .progVoltageOk(progVoltageOk), .otpData(IMG), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
    .windowOpen_q(windowOpen_q), .progPulse_q(progPulse_q), .otpProgData_q(otpProgData_q),
    .conversionTimeSel_q(conversionTimeSel_q), .auxInputRefSel_q(auxInputRefSel_q),
    .auxInputSrcSel_q(auxInputSrcSel_q), .cellEnable_q(cellEnable_q), .crcOff_q(crcOff_q),
    .ovEnable_q(ovEnable_q), .ovThresholdMv_q(ovThresholdMv_q), .ovUnitMs_q(ovUnitMs_q),
    .ovDelay_q(ovDelay_q), .ovLatch_q(ovLatch_q), .uvEnable_q(uvEnable_q),
    .uvThresholdMv_q(uvThresholdMv_q), .uvUnitMs_q(uvUnitMs_q), .uvDelay_q(uvDelay_q),
    .uvLatch_q(uvLatch_q), .otThresholdFirst_q(otThresholdFirst_q),
    .otThresholdSecond_q(otThresholdSecond_q), .otDelayMs_q(otDelayMs_q),
    .otLatch_q(otLatch_q));
  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Decoded outputs trail the bank by one cycle
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00);
    chk("read valid", 1'b1, rdValid_q);
    @(posedge clk) #1;
    chk("read data", e, rdData_q);
  endtask
  task automatic t_reset_load;
    chk("conv time", 2'b01, conversionTimeSel_q);
    chk("aux ref", 1'b1, auxInputRefSel_q);
    chk("cells", 6'h1F, cellEnable_q);
    chk("crc off", 1'b1, crcOff_q);
    chk("ov mv", 16'h1388, ovThresholdMv_q);
    chk("ot delay", 16'h0064, otDelayMs_q);
    chk("aux src", 1'b0, auxInputSrcSel_q);
    chk("uv enable", 1'b1, uvEnable_q);
    chk("uv mv", 16'h0CE4, uvThresholdMv_q);
    chk("uv unit", 1'b0, uvUnitMs_q);
    chk("ot first", 4'h1, otThresholdFirst_q);
    chk("ot second", 4'h2, otThresholdSecond_q);
    chk("ov latch", 1'b0, ovLatch_q);
    chk("uv latch", 1'b0, uvLatch_q);
    chk("ot latch", 1'b1, otLatch_q);
  endtask
  task automatic t_key;
    host.xfer(1'b1, 8'h42, 8'h00);
    rd(8'h42, 8'h3C);
    host.prot(8'h42, 8'h85);
    settle();
    chk("ov enable", 1'b0, ovEnable_q);
    chk("ov mv", 16'h08CA, ovThresholdMv_q);
    host.xfer(1'b1, 8'h42, 8'h00);
    rd(8'h42, 8'h85);
  endtask
  task automatic t_fields;
    for (int i = 0; i < 4; i++) begin
      host.prot(8'h40, {i[1:0], i[0], i[1], i[1:0], 2'b00});
      settle();
      chk("conv time", i[1:0], conversionTimeSel_q);
      chk("aux src", i[1], auxInputSrcSel_q);
      chk("aux ref", i[0], auxInputRefSel_q);
      chk("cells", 6'h3F >> i, cellEnable_q);
    end
    host.prot(8'h41, 8'h00);
    host.prot(8'h43, 8'h9F);
    host.prot(8'h44, 8'h9F);
    host.prot(8'h45, 8'h81);
    host.prot(8'h46, 8'hB3);
    host.prot(8'h47, 8'hFF);
    settle();
    chk("uv enable", 1'b0, uvEnable_q);
    chk("uv mv", 16'h0CE4, uvThresholdMv_q);
    chk("uv unit", 1'b1, uvUnitMs_q);
    chk("ot first", 4'h3, otThresholdFirst_q);
    chk("ot second", 4'hB, otThresholdSecond_q);
    chk("ov latch", 1'b1, ovLatch_q);
    chk("uv latch", 1'b1, uvLatch_q);
    chk("ot latch", 1'b1, otLatch_q);
    chk("crc off", 1'b0, crcOff_q);
    chk("ov unit", 1'b1, ovUnitMs_q);
    chk("ov delay", 16'h0C1C, ovDelay_q);
    chk("uv delay", 16'h0064, uvDelay_q);
    chk("ot delay", 16'h09F6, otDelayMs_q);
  endtask
  task automatic t_user_reload;
    host.prot(8'h4B, 8'hA5);
    rd(8'h4B, 8'hA5);
    rd(8'h3A, 8'h00);
    rd(8'h50, 8'h00);
    host.xfer(1'b1, 8'h3A, 8'h27);
    rd(8'h42, 8'h3C);
    host.xfer(1'b1, 8'h42, 8'h00);
    rd(8'h42, 8'h3C);
  endtask
  task automatic t_unlock;
    progVoltageOk = 1'b1;
    host.xfer(1'b1, 8'h3F, 8'h91);
    chk("window", 1'b1, windowOpen_q);
    chk("pulse", 1'b1, progPulse_q);
    chk("image", IMG, otpProgData_q);
    rd(8'h3F, 8'h00);
    chk("window", 1'b0, windowOpen_q);
    repeat (12) @(posedge clk);
    #1;
    chk("pulse", 1'b0, progPulse_q);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard well above the roughly 150 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    reset = 1'b1;
    progVoltageOk = 1'b0;
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    settle();
    t_reset_load();
    t_key();
    t_fields();
    t_user_reload();
    t_unlock();
    stop_test();
  end
endmodule // pocr_protected_config_tb
`default_nettype wire
